/* File: logic/gses_seq.sv */
/*
 Global-shutter exposure and readout sequencer with an AXI4-Lite register
 slave. Assumes a single 25 MHz clock; exposure pins synchronous to it.
*/
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - Every frame readout opens with frame overhead
// - Each line: row overhead, then 54 kernels
// - Kernel read as two 12-pixel halves
// - One config bit picks master or slave
// - Slave: pins set integration, readout internal
// - Pipelined: integrate N while reading N-1
// - Config bit selects lines or cycles
// - Master line counting changes signals only in ROT or while readout is idle
// - Cycle counts scaled by two to power
// - Cycle mode: immediate, or delayed to ROT
// - Delay bit aligns slave pins to ROT
// - Overhead timers always count clock cycles
// - Pipelined slave: pin rise exposes, fall samples
// - Triggered: one image per request
// - Triggered master: rise starts, timer ends
// - Triggered master: reset during readout, new rise
// - Triggered slave: fall starts readout
// - Samples per reset from count register
// - Multi-sample slave suppresses array reset
// - Dummy reference line read before pixels
// - Monitors high during each slope integration
// - Active-low reset, single system clock
module gses_seq (
   input  wire logic               i_clk,
   input  wire logic               i_rst_n,
   input  wire logic [7:0]         s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [7:0]         s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic [2:0]         i_exposure_pin,
   output logic [2:0]              o_monitor,
   output logic                    o_array_reset,
   output logic                    o_sample,
   output logic                    o_training,
   output gses_pkg::gses_rd_t      o_rd
);
   import gses_pkg::*;

   gses_cfg_t       cfg;
   gses_rd_state_t  rd_state;
   gses_exp_state_t exp_state;
   logic [15:0]     ovh_cnt;
   logic [15:0]     line_cnt;
   logic [7:0]      ndr_cnt;
   logic            aw_hold, w_hold;
   logic [7:0]      aw_addr;
   logic [31:0]     w_data;
   logic [2:0]      pin_q;
   logic [2:0]      pin_eff;
   logic            rot_start, frame_go, frame_busy;
   logic            res_exp, tint_exp, ds_exp, ts_exp, tint_busy, ds_busy, ts_busy;
   logic            start_res, start_tint;
   logic            pend_res, pend_tint;
   logic            apply_now;

   // AXI4-Lite write: address and data taken in either order
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold && !s_axi_bvalid;
   assign s_axi_bresp   = 2'b00;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_rresp   = 2'b00;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         aw_hold      <= 1'b0;
         w_hold       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         cfg          <= '0;
         cfg.fot      <= GSES_RST_FOT;
         cfg.rot      <= GSES_RST_ROT;
         cfg.tint     <= GSES_RST_TINT;
         cfg.res_len  <= GSES_RST_RES;
         cfg.lines    <= GSES_RST_LINES;
         cfg.ndr      <= GSES_RST_NDR;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
         end
         if (aw_hold && w_hold) begin
            aw_hold      <= 1'b0;
            w_hold       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // Byte strobes ignored: every field fits the low half-word
            if (aw_addr == GSES_OFF_CFG_A) begin
               cfg.enable    <= w_data[GSES_BIT_ENABLE];
               cfg.slave     <= w_data[GSES_BIT_SLAVE];
               cfg.triggered <= w_data[GSES_BIT_TRIGGERED];
            end else if (aw_addr == GSES_OFF_CFG_C) begin
               cfg.in_cycles <= w_data[GSES_BIT_CYCLES];
               cfg.delay_rot <= w_data[GSES_BIT_DELAY];
            end else if (aw_addr == GSES_OFF_CFG_D) begin
               cfg.scale <= w_data[3:0];
            end else if (aw_addr == GSES_OFF_RES_LEN) begin
               cfg.res_len <= w_data[15:0];
            end else if (aw_addr == GSES_OFF_TINT) begin
               cfg.tint <= w_data[15:0];
            end else if (aw_addr == GSES_OFF_TINT_DS) begin
               cfg.tint_ds <= w_data[15:0];
            end else if (aw_addr == GSES_OFF_TINT_TS) begin
               cfg.tint_ts <= w_data[15:0];
            end else if (aw_addr == GSES_OFF_FOT) begin
               cfg.fot <= w_data[15:0];
            end else if (aw_addr == GSES_OFF_ROT) begin
               cfg.rot <= w_data[15:0];
            end else if (aw_addr == GSES_OFF_NDR) begin
               cfg.ndr <= w_data[7:0];
            end else if (aw_addr == GSES_OFF_LINES) begin
               cfg.lines <= w_data[15:0];
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read side: one-cycle answer, unmapped reads return zero with OKAY
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         if (s_axi_araddr == GSES_OFF_CFG_A) begin
            s_axi_rdata <= {29'h0, cfg.triggered, cfg.slave, cfg.enable};
         end else if (s_axi_araddr == GSES_OFF_CFG_C) begin
            s_axi_rdata <= {24'h0, cfg.delay_rot, cfg.in_cycles, 6'h00};
         end else if (s_axi_araddr == GSES_OFF_CFG_D) begin
            s_axi_rdata <= {28'h0, cfg.scale};
         end else if (s_axi_araddr == GSES_OFF_RES_LEN) begin
            s_axi_rdata <= {16'h0, cfg.res_len};
         end else if (s_axi_araddr == GSES_OFF_TINT) begin
            s_axi_rdata <= {16'h0, cfg.tint};
         end else if (s_axi_araddr == GSES_OFF_TINT_DS) begin
            s_axi_rdata <= {16'h0, cfg.tint_ds};
         end else if (s_axi_araddr == GSES_OFF_TINT_TS) begin
            s_axi_rdata <= {16'h0, cfg.tint_ts};
         end else if (s_axi_araddr == GSES_OFF_FOT) begin
            s_axi_rdata <= {16'h0, cfg.fot};
         end else if (s_axi_araddr == GSES_OFF_ROT) begin
            s_axi_rdata <= {16'h0, cfg.rot};
         end else if (s_axi_araddr == GSES_OFF_NDR) begin
            s_axi_rdata <= {24'h0, cfg.ndr};
         end else if (s_axi_araddr == GSES_OFF_LINES) begin
            s_axi_rdata <= {16'h0, cfg.lines};
         end else if (s_axi_araddr == GSES_OFF_STATUS) begin
            s_axi_rdata <= {8'h0, line_cnt, 2'b00, exp_state, rd_state, o_array_reset};
         end else begin
            s_axi_rdata <= 32'h0000_0000;
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign o_training = !cfg.enable;
   assign frame_busy = rd_state != GSES_IDLE;

   // Readout engine: FOT, then dummy line, then real lines
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_state <= GSES_IDLE;
         ovh_cnt  <= 16'h0000;
         line_cnt <= 16'h0000;
         o_rd     <= '0;
      end else begin
         case (rd_state)
            GSES_IDLE: begin
               o_rd <= '0;
               if (frame_go) begin
                  rd_state    <= GSES_FOT;
                  ovh_cnt     <= 16'h0000;
                  o_rd.in_fot <= 1'b1;
               end
            end
            GSES_FOT: begin
               ovh_cnt <= ovh_cnt + 16'h0001;
               if (ovh_cnt + 16'h0001 >= cfg.fot) begin
                  rd_state        <= GSES_ROT;
                  ovh_cnt         <= 16'h0000;
                  line_cnt        <= 16'h0000;
                  o_rd.in_fot     <= 1'b0;
                  o_rd.in_rot     <= 1'b1;
                  o_rd.dummy_line <= 1'b1;
               end
            end
            GSES_ROT: begin
               ovh_cnt <= ovh_cnt + 16'h0001;
               if (ovh_cnt + 16'h0001 >= cfg.rot) begin
                  rd_state      <= GSES_LINE;
                  o_rd.in_rot   <= 1'b0;
                  o_rd.in_line  <= 1'b1;
                  o_rd.kernel   <= 6'h00;
                  o_rd.half_sel <= 1'b0;
               end
            end
            GSES_LINE: begin
               // Two 12-pixel halves per kernel; a clock of the one-clock design
               o_rd.half_sel <= !o_rd.half_sel;
               if (o_rd.half_sel) begin
                  if (o_rd.kernel == GSES_KERNELS - 6'h01) begin
                     o_rd.in_line    <= 1'b0;
                     o_rd.dummy_line <= 1'b0;
                     line_cnt        <= o_rd.dummy_line ? 16'h0000 : line_cnt + 16'h0001;
                     if (!o_rd.dummy_line && line_cnt + 16'h0001 >= cfg.lines) begin
                        rd_state <= GSES_DONE;
                     end else begin
                        rd_state    <= GSES_ROT;
                        ovh_cnt     <= 16'h0000;
                        o_rd.in_rot <= 1'b1;
                     end
                  end else begin
                     o_rd.kernel <= o_rd.kernel + 6'h01;
                  end
               end
            end
            default: begin
               rd_state <= GSES_IDLE;
            end
         endcase
      end
   end

   assign rot_start = o_rd.in_rot && ovh_cnt == 16'h0000;

   // Signal changes allowed now, or during readout only at the next row overhead
   assign apply_now = (cfg.in_cycles && !cfg.delay_rot) || rot_start || !frame_busy;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pin_q <= 3'b000;
      end else if (!cfg.delay_rot || rot_start || !frame_busy) begin
         pin_q <= i_exposure_pin;
      end
   end
   assign pin_eff = pin_q;

   // Idle line pacer: without it line-counted timers stall between frames
   logic [15:0] pace_cnt;
   logic        line_tick;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || frame_busy) begin
         pace_cnt <= 16'h0000;
      end else if (pace_cnt + 16'h0001 >= cfg.rot + 16'(2 * GSES_KERNELS)) begin
         pace_cnt <= 16'h0000;
      end else begin
         pace_cnt <= pace_cnt + 16'h0001;
      end
   end
   assign line_tick = rot_start || (!frame_busy && pace_cnt == 16'h0000);

   gses_timer u_res (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start_res),
      .i_in_cycles(cfg.in_cycles), .i_scale(cfg.scale), .i_line(line_tick),
      .i_len(cfg.res_len), .o_busy(), .o_expired(res_exp));
   gses_timer u_tint (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start_tint),
      .i_in_cycles(cfg.in_cycles), .i_scale(cfg.scale), .i_line(line_tick),
      .i_len(cfg.tint), .o_busy(tint_busy), .o_expired(tint_exp));
   gses_timer u_ds (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start_tint),
      .i_in_cycles(cfg.in_cycles), .i_scale(cfg.scale), .i_line(line_tick),
      .i_len(cfg.tint_ds), .o_busy(ds_busy), .o_expired(ds_exp));
   gses_timer u_ts (
      .i_clk(i_clk), .i_rst_n(i_rst_n), .i_start(start_tint),
      .i_in_cycles(cfg.in_cycles), .i_scale(cfg.scale), .i_line(line_tick),
      .i_len(cfg.tint_ts), .o_busy(ts_busy), .o_expired(ts_exp));

   // Exposure control; a trigger rise is seen on the effective pin
   logic pin1_d;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         exp_state     <= GSES_X_RESET;
         o_array_reset <= 1'b1;
         o_sample      <= 1'b0;
         frame_go      <= 1'b0;
         start_res     <= 1'b0;
         start_tint    <= 1'b0;
         pend_res      <= 1'b0;
         pend_tint     <= 1'b0;
         ndr_cnt       <= 8'h00;
         pin1_d        <= 1'b0;
         o_monitor     <= 3'b000;
      end else begin
         pin1_d     <= pin_eff[0];
         frame_go   <= 1'b0;
         o_sample   <= 1'b0;
         start_res  <= 1'b0;
         start_tint <= 1'b0;
         if (res_exp) pend_res <= 1'b1;
         if (tint_exp) pend_tint <= 1'b1;
         if (!cfg.enable) begin
            exp_state     <= GSES_X_RESET;
            o_array_reset <= 1'b1;
            o_monitor     <= 3'b000;
            pend_res      <= 1'b0;
            pend_tint     <= 1'b0;
         end else if (cfg.slave) begin
            // Slave: pins drive integration; monitors follow pins
            o_monitor <= pin_eff;
            if (pin_eff[0] && !pin1_d && !(cfg.triggered && frame_busy)) begin
               // Later samples keep array out of reset
               o_array_reset <= 1'b0;
               exp_state     <= GSES_X_INTEG;
            end else if (!pin_eff[0] && pin1_d && exp_state == GSES_X_INTEG) begin
               o_sample  <= 1'b1;
               frame_go  <= 1'b1;
               ndr_cnt   <= (ndr_cnt + 8'h01 >= cfg.ndr) ? 8'h00 : ndr_cnt + 8'h01;
               exp_state <= GSES_X_RESET;
               if (cfg.triggered || ndr_cnt + 8'h01 >= cfg.ndr) begin
                  o_array_reset <= 1'b1;
               end
            end
         end else begin
            case (exp_state)
               GSES_X_RESET: begin
                  o_array_reset <= 1'b1;
                  o_monitor     <= 3'b000;
                  if (cfg.triggered) begin
                     if (pin_eff[0] && !pin1_d && !frame_busy) begin
                        start_tint    <= 1'b1;
                        o_array_reset <= 1'b0;
                        exp_state     <= GSES_X_INTEG;
                     end
                  end else begin
                     start_res <= 1'b1;
                     exp_state <= GSES_X_WAIT;
                  end
               end
               GSES_X_WAIT: begin
                  if ((res_exp || pend_res) && apply_now) begin
                     pend_res      <= 1'b0;
                     o_array_reset <= 1'b0;
                     start_tint    <= 1'b1;
                     exp_state     <= GSES_X_INTEG;
                  end
               end
               default: begin
                  o_monitor <= {ts_busy, ds_busy, tint_busy};
                  if ((tint_exp || pend_tint) && apply_now) begin
                     pend_tint <= 1'b0;
                     o_sample  <= 1'b1;
                     frame_go  <= 1'b1;
                     ndr_cnt   <= (ndr_cnt + 8'h01 >= cfg.ndr) ? 8'h00 : ndr_cnt + 8'h01;
                     if (!cfg.triggered && ndr_cnt + 8'h01 < cfg.ndr) begin
                        start_tint <= 1'b1;
                     end else begin
                        exp_state     <= GSES_X_RESET;
                        o_array_reset <= 1'b1;
                     end
                  end
               end
            endcase
         end
      end
   end

   property p_line_after_rot;
      @(posedge i_clk) disable iff (!i_rst_n)
      (rd_state == GSES_ROT && $past(rd_state) == GSES_FOT) |-> o_rd.dummy_line;
   endproperty
   a_line_after_rot: assert property (p_line_after_rot)
      else $error("First line after FOT is not dummy");

   property p_fot_first;
      @(posedge i_clk) disable iff (!i_rst_n)
      ($past(rd_state) == GSES_IDLE && rd_state != GSES_IDLE) |-> rd_state == GSES_FOT;
   endproperty
   a_fot_first: assert property (p_fot_first)
      else $error("Frame did not open with FOT");

   property p_halves;
      @(posedge i_clk) disable iff (!i_rst_n)
      (rd_state == GSES_LINE && !o_rd.half_sel) |=> o_rd.half_sel || rd_state != GSES_LINE;
   endproperty
   a_halves: assert property (p_halves)
      else $error("Kernel half sequence broken");

   property p_lines_rot;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!cfg.in_cycles && !cfg.slave && frame_busy && $fell(o_array_reset)) |-> $past(rot_start);
   endproperty
   a_lines_rot: assert property (p_lines_rot)
      else $error("Line-mode reset release outside ROT");

   property p_sample_go;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_sample |-> frame_go;
   endproperty
   a_sample_go: assert property (p_sample_go)
      else $error("Sample without readout start");

   property p_trig_reset;
      @(posedge i_clk) disable iff (!i_rst_n)
      (cfg.triggered && cfg.enable && rd_state == GSES_LINE) |-> o_array_reset;
   endproperty
   a_trig_reset: assert property (p_trig_reset)
      else $error("Array left reset during triggered readout");

   property p_rst_idle;
      @(posedge i_clk) !i_rst_n |=> rd_state == GSES_IDLE && o_array_reset;
   endproperty
   a_rst_idle: assert property (p_rst_idle)
      else $error("Reset did not idle sequencer");

   property p_kernel_max;
      @(posedge i_clk) disable iff (!i_rst_n)
      o_rd.in_line |-> o_rd.kernel < GSES_KERNELS;
   endproperty
   a_kernel_max: assert property (p_kernel_max)
      else $error("Kernel index beyond 54");
endmodule : gses_seq

/* File: logic/gses_pkg.sv */
/*
 Package of the exposure and readout sequencer: register map, field positions,
 reset values, states and the carrier structs shared by the design files.
 Assumes an AXI4-Lite master with 32-bit data and one 25 MHz clock.
*/
package gses_pkg;
   // Register byte offsets
   localparam logic [7:0] GSES_OFF_CFG_A   = 8'h00;
   localparam logic [7:0] GSES_OFF_CFG_C   = 8'h04;
   localparam logic [7:0] GSES_OFF_CFG_D   = 8'h08;
   localparam logic [7:0] GSES_OFF_RES_LEN = 8'h0C;
   localparam logic [7:0] GSES_OFF_TINT    = 8'h10;
   localparam logic [7:0] GSES_OFF_TINT_DS = 8'h14;
   localparam logic [7:0] GSES_OFF_TINT_TS = 8'h18;
   localparam logic [7:0] GSES_OFF_FOT     = 8'h1C;
   localparam logic [7:0] GSES_OFF_ROT     = 8'h20;
   localparam logic [7:0] GSES_OFF_NDR     = 8'h24;
   localparam logic [7:0] GSES_OFF_LINES   = 8'h28;
   localparam logic [7:0] GSES_OFF_STATUS  = 8'h2C;
   // Field positions
   localparam int GSES_BIT_ENABLE    = 0;
   localparam int GSES_BIT_SLAVE     = 1;
   localparam int GSES_BIT_TRIGGERED = 2;
   localparam int GSES_BIT_CYCLES    = 6;
   localparam int GSES_BIT_DELAY     = 7;
   // Reset values
   localparam logic [15:0] GSES_RST_FOT   = 16'h013B;
   localparam logic [15:0] GSES_RST_ROT   = 16'h0009;
   localparam logic [15:0] GSES_RST_TINT  = 16'h0400;
   localparam logic [15:0] GSES_RST_RES   = 16'h0010;
   localparam logic [15:0] GSES_RST_LINES = 16'h0400;
   localparam logic [7:0]  GSES_RST_NDR   = 8'h01;
   // Line geometry
   localparam logic [5:0] GSES_KERNELS   = 6'h36;
   localparam logic [4:0] GSES_KERNEL_PX = 5'h18;
   localparam logic [3:0] GSES_HALF_PX   = 4'hC;

   typedef enum logic [2:0] {
      GSES_IDLE  = 3'b000,
      GSES_FOT   = 3'b001,
      GSES_ROT   = 3'b010,
      GSES_LINE  = 3'b011,
      GSES_DONE  = 3'b100
   } gses_rd_state_t;

   typedef enum logic [1:0] {
      GSES_X_RESET = 2'b00,
      GSES_X_WAIT  = 2'b01,
      GSES_X_INTEG = 2'b10
   } gses_exp_state_t;

   typedef struct packed {
      logic        enable;
      logic        slave;
      logic        triggered;
      logic        in_cycles;
      logic        delay_rot;
      logic [3:0]  scale;
      logic [15:0] res_len;
      logic [15:0] tint;
      logic [15:0] tint_ds;
      logic [15:0] tint_ts;
      logic [15:0] fot;
      logic [15:0] rot;
      logic [7:0]  ndr;
      logic [15:0] lines;
   } gses_cfg_t;

   typedef struct packed {
      logic       in_fot;
      logic       in_rot;
      logic       in_line;
      logic       dummy_line;
      logic       half_sel;
      logic [5:0] kernel;
   } gses_rd_t;
endpackage : gses_pkg

/* File: logic/gses_timer.sv */
/*
 Exposure interval timer counting either lines or scaled clock cycles.
 Assumes i_line pulses once per row-overhead start and i_start is one cycle.
*/
`timescale 1ns/1ps
module gses_timer #(
   parameter int W = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst_n,
   input  wire logic         i_start,
   input  wire logic         i_in_cycles,
   input  wire logic [3:0]   i_scale,
   input  wire logic         i_line,
   input  wire logic [W-1:0] i_len,
   output logic              o_busy,
   output logic              o_expired
);
   import gses_pkg::*;
   logic [W+14:0] count;
   logic [W+14:0] target;
   logic          tick;

   // Cycle mode scales by two to the power of the scale field
   assign target = i_in_cycles ? ((W+15)'(i_len) << i_scale) : (W+15)'(i_len);
   assign tick   = i_in_cycles | i_line;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         count     <= '0;
         o_busy    <= 1'b0;
         o_expired <= 1'b0;
      end else begin
         o_expired <= 1'b0;
         if (i_start) begin
            count  <= '0;
            o_busy <= 1'b1;
         end else if (o_busy && tick) begin
            if (count + (W+15)'(1) >= target) begin
               o_busy    <= 1'b0;
               o_expired <= 1'b1;
            end
            count <= count + (W+15)'(1);
         end
      end
   end
endmodule : gses_timer

/* File: testbench/gses_ctrl_model.sv */
/*
 Camera controller model driving the exposure pins in slave and triggered master operation.
 Assumes the bench calls its tasks just after a rising edge of i_clk.
*/
`timescale 1ns/1ps
module gses_ctrl_model (
   input  wire logic       i_clk,
   output logic [2:0]      o_pins
);
   initial o_pins = 3'h0;
   // Pins move only right after an edge, like a real synchronous driver
   task automatic rise();
      @(posedge i_clk);
      o_pins <= 3'h1;
   endtask : rise
   // Issued while readout is idle, so no line readout is disturbed
   task automatic fall();
      @(posedge i_clk);
      o_pins <= 3'h0;
   endtask : fall
endmodule : gses_ctrl_model

/* File: testbench/gses_seq_test.sv */
/*
 Self-checking bench of the sequencer: registers over AXI4-Lite, triggered
 frames in slave and master mode. Assumes gses_pkg and the model; 25 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module gses_seq_test;
   import gses_pkg::*;
   logic i_clk, i_rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_arvalid, s_axi_arready, s_axi_rvalid, o_array_reset;
   logic s_axi_bready, s_axi_rready, o_sample, o_training;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, fot, t;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [2:0] i_exposure_pin, o_monitor;
   gses_rd_t o_rd;
   int n_errors = 0, n_tests = 0, nf, nr, na, ns, nm, nd;
   logic [5:0] kmax;
   gses_seq i_dut (.*);
   gses_ctrl_model i_ctrl (.i_clk(i_clk), .o_pins(i_exposure_pin));
   function automatic int rot_cycles(input int lines, input int rot);
      return (lines + 1) * rot; // Dummy line has its own ROT
   endfunction : rot_cycles
   function automatic int scaled(input int v, input int s);
      return v << s; // Cycle counts grow by two to the power s
   endfunction : scaled
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic ta, tw, tb;
      s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
      do begin
         @(negedge i_clk);
         ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         @(posedge i_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end while (!tb);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      logic ta, tr;
      s_axi_araddr <= a; s_axi_arvalid <= 1'b1;
      do begin
         @(negedge i_clk);
         ta = s_axi_arvalid & s_axi_arready; tr = s_axi_rvalid; v = s_axi_rdata;
         @(posedge i_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end while (!tr);
   endtask : rd
   // In triggered mode the array may leave reset only outside readout
   task automatic count_frame(input int n);
      {nf, nr, na, ns, nm, nd} = '0;
      kmax = '0;
      repeat (n) begin
         @(negedge i_clk);
         nf += o_rd.in_fot;
         nr += o_rd.in_rot;
         ns += o_sample;
         nm += o_monitor[0];
         nd += o_rd.in_line && o_rd.dummy_line;
         na += !o_array_reset && (o_rd.in_fot || o_rd.in_rot || o_rd.in_line);
         if (o_rd.kernel > kmax)
            kmax = o_rd.kernel;
      end
   endtask : count_frame
   task automatic end_of_test();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_of_test
   initial begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   initial begin
      repeat (20000) @(posedge i_clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, i_rst_n} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF; s_axi_bready = 1'b1; s_axi_rready = 1'b1;
      void'($urandom(12354));
      repeat (4) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(negedge i_clk);
      `CHK({o_training, o_array_reset, o_monitor}, 5'h18)
      `CHK(o_rd, '0)
      @(posedge i_clk);
      rd(GSES_OFF_FOT, d); `CHK(d[15:0], GSES_RST_FOT)
      rd(GSES_OFF_ROT, d); `CHK(d[15:0], GSES_RST_ROT)
      rd(GSES_OFF_NDR, d); `CHK(d[7:0], GSES_RST_NDR)
      rd(8'h30, d); `CHK(d, 32'h0)
      fot = 32'h8 + ($urandom % 16);
      wr(GSES_OFF_TINT_DS, fot); rd(GSES_OFF_TINT_DS, d); `CHK(d[15:0], fot[15:0])
      wr(GSES_OFF_FOT, fot);
      wr(GSES_OFF_ROT, 32'h5);
      wr(GSES_OFF_LINES, 32'h2);
      wr(GSES_OFF_CFG_C, 32'h0);
      wr(GSES_OFF_CFG_A, 32'h7);
      `CHK(o_training, 1'b0)
      repeat (5) @(posedge i_clk);
      `CHK(o_array_reset, 1'b1)
      i_ctrl.rise();
      repeat (5) @(posedge i_clk);
      `CHK({o_array_reset, o_monitor[0]}, 2'b01)
      i_ctrl.fall();
      count_frame(fot + 3 * 113 + 40);
      `CHK(ns, 1)
      `CHK(nf, fot)
      `CHK(nr, rot_cycles(2, 5))
      `CHK(nd, 2 * GSES_KERNELS)
      `CHK(kmax, GSES_KERNELS - 6'h1)
      `CHK(na, 0)
      `CHK(o_monitor[0], 1'b0)
      // Triggered master, cycle counting scaled by two; pin stays high
      @(posedge i_clk);
      wr(GSES_OFF_CFG_A, 32'h0);
      wr(GSES_OFF_CFG_C, 32'h40);
      wr(GSES_OFF_CFG_D, 32'h1);
      t = 32'h3 + ($urandom % 8);
      wr(GSES_OFF_TINT, t);
      wr(GSES_OFF_CFG_A, 32'h5);
      i_ctrl.rise();
      count_frame(fot + 3 * 113 + 40 + scaled(t, 1));
      `CHK(ns, 1)
      `CHK(nm, scaled(t, 1))
      `CHK(nf, fot)
      `CHK(na, 0)
      end_of_test();
   end
endmodule : gses_seq_test
